// >>> spicst_pkg.sv
// Shared constants for the serial peripheral chip-select configuration block
package spicst_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;  // Enable control
  localparam logic [7:0] OFF_MODE   = 8'h04;  // Select mode
  localparam logic [7:0] OFF_RXDATA = 8'h08;  // Received character
  localparam logic [7:0] OFF_TXDATA = 8'h0C;  // Character to send
  localparam logic [7:0] OFF_STATUS = 8'h10;  // Sticky event flags
  localparam logic [7:0] OFF_IEN    = 8'h14;  // interrupt_enable_reg
  localparam logic [7:0] OFF_IDIS   = 8'h18;  // interrupt_disable_reg
  localparam logic [7:0] OFF_IMASK  = 8'h1C;  // spi_interrupt_mask_view
  localparam logic [7:0] OFF_CFG0   = 8'h30;  // peripheral_config_0
  localparam logic [7:0] OFF_CFG3   = 8'h3C;  // peripheral_config_3

  // ------------------------------------------------------------
  // Event bit positions (status and mask share the layout)
  // ------------------------------------------------------------
  localparam int EV_RX_FULL      = 0;
  localparam int EV_TX_EMPTY_REG = 1;
  localparam int EV_MODE_FAULT   = 2;
  localparam int EV_OVERRUN      = 3;
  localparam int EV_RX_BUF_END   = 4;
  localparam int EV_TX_BUF_END   = 5;
  localparam int EV_RX_BUF_FULL  = 6;
  localparam int EV_TX_BUF_EMPTY = 7;
  localparam int EV_SELECT_RISE  = 8;
  localparam int EV_TX_ALL_EMPTY = 9;
  localparam int EV_W            = 10;

  // ------------------------------------------------------------
  // Configuration word fields
  // ------------------------------------------------------------
  localparam int CF_IDLE_LEVEL = 0;   // clock_idle_level
  localparam int CF_PHASE      = 1;   // clock_phase
  localparam int CF_HOLD       = 3;   // hold_select
  localparam int CF_BITS_LO    = 4;   // Character width code
  localparam int CF_BITS_HI    = 7;
  localparam int CF_DIV_LO     = 8;   // clock_divider
  localparam int CF_DIV_HI     = 15;
  localparam int CF_PRE_LO     = 16;  // pre_clock_delay
  localparam int CF_PRE_HI     = 23;
  localparam int CF_GAP_LO     = 24;  // inter_char_delay
  localparam int CF_GAP_HI     = 31;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Control, mode and data fields
  // ------------------------------------------------------------
  localparam int CT_ENABLE   = 0;
  localparam int MD_VAR_SEL  = 1;
  localparam int PCS_LO      = 16;
  localparam int PCS_HI      = 19;
  localparam int TD_LAST     = 24;
  localparam int ST_ENABLED  = 16;

  // ------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------
  localparam logic [4:0] BITS_BASE    = 5'h08;  // Width for code 0
  localparam logic [3:0] BITS_MAXCODE = 4'h8;   // Highest legal code
  localparam logic [7:0] MIN_PERIOD   = 8'h02;  // Shortest bit period
  localparam int         GAP_SHIFT    = 5;      // Gap unit of 32 clocks
  localparam logic [3:0] PCS_NONE     = 4'hF;

endpackage

// >>> spicst_cfg_bank.sv
// Four-word bank holding the per-select configuration words
`timescale 1ns/1ps
module spicst_cfg_bank
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [1:0]  bus_idx,
  output logic      [31:0] bus_rdata,
  input  wire logic [1:0]  eng_idx,
  output logic      [31:0] eng_rdata
);
  import spicst_pkg::*;

  logic [31:0] words [0:3];  // One word per chip select

  // ------------------------------------------------------------
  // Storage and registered read ports
  // ------------------------------------------------------------
  // Writes and both read ports; reads lag the index by one clock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        words[i] <= CFG_RESET;
      bus_rdata <= CFG_RESET;
      eng_rdata <= CFG_RESET;
    end
    else
    begin
      if (wr_en)
        words[wr_idx] <= wr_data;
      bus_rdata <= words[bus_idx];
      eng_rdata <= words[eng_idx];
    end
  end

endmodule

// >>> spicst_top.sv
// Serial master with per-select configuration, APB registers and interrupt
`timescale 1ns/1ps
module spicst_top
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             serial_clock,
  output logic             mosi,
  input  wire logic        miso,
  output logic [3:0]       peripheral_select_line_n
);
  import spicst_pkg::*;

  typedef enum logic [1:0] {SPICST_IDLE, SPICST_SETUP, SPICST_SHIFT, SPICST_GAP} spicst_state_t;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Select code to index; all-ones is forbidden and maps to 3
  function automatic logic [1:0] pcs_index(input logic [3:0] pcs);
    if (!pcs[0])
      return 2'd0;
    else if (!pcs[1])
      return 2'd1;
    else if (!pcs[2])
      return 2'd2;
    else
      return 2'd3;
  endfunction

  // Character width from code; reserved codes clamp to sixteen
  function automatic logic [4:0] char_width(input logic [31:0] cfg);
    logic [3:0] code;
    code = cfg[CF_BITS_HI:CF_BITS_LO];
    if (code > BITS_MAXCODE)
      code = BITS_MAXCODE;
    return BITS_BASE + {1'b0, code};
  endfunction

  // Bit period in clocks; a divider below two cannot be toggled
  function automatic logic [7:0] bit_period(input logic [31:0] cfg);
    logic [7:0] div;
    div = cfg[CF_DIV_HI:CF_DIV_LO];
    return (div < MIN_PERIOD) ? MIN_PERIOD : div;
  endfunction

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic              enabled;       // Block enable
  logic              var_sel;       // Select taken from each character
  logic [3:0]        fixed_pcs;     // Select code when not variable
  logic [EV_W-1:0]   status;        // Sticky event flags
  logic [EV_W-1:0]   mask;          // Interrupt enables
  logic [15:0]       rx_data;       // Last received character
  logic [1:0]        rx_pcs;        // Select that received it
  logic [15:0]       hold_data;     // Transmit holding register
  logic [3:0]        hold_pcs;      // Its select code
  logic              hold_last;     // Its last-transfer flag
  logic              pend;          // Holding register is full
  logic              pend_aged;     // Config read for it is valid
  logic              ack_wait;      // APB second wait cycle
  logic [1:0]        miso_meta;     // Input synchroniser stages
  logic              miso_s;        // Synchronised data input

  // ------------------------------------------------------------
  // Transfer engine state
  // ------------------------------------------------------------
  spicst_state_t     state;
  logic [31:0]       cfg;           // Configuration of active character
  logic [12:0]       cnt;           // Delay or bit-phase counter
  logic [4:0]        bits;          // Bits sampled so far
  logic [15:0]       tx_sh;         // Outgoing shifter
  logic [15:0]       rx_sh;         // Incoming shifter
  logic [1:0]        cur_cs;        // Active select index
  logic              cur_last;      // Active character ends selection
  logic              sel_active;    // A select line is driven low

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire         bus_fire  = psel & penable & pready;
  wire         wr_fire   = bus_fire & pwrite;
  wire         is_cfg    = (paddr >= OFF_CFG0) && (paddr <= OFF_CFG3) && (paddr[1:0] == 2'b00);
  wire         is_ctrl   = (paddr == OFF_CTRL);
  wire         is_mode   = (paddr == OFF_MODE);
  wire         is_rx     = (paddr == OFF_RXDATA);
  wire         is_tx     = (paddr == OFF_TXDATA);
  wire         is_stat   = (paddr == OFF_STATUS);
  wire         is_ien    = (paddr == OFF_IEN);
  wire         is_idis   = (paddr == OFF_IDIS);
  wire         is_imask  = (paddr == OFF_IMASK);
  wire         mapped    = is_cfg | is_ctrl | is_mode | is_rx | is_tx | is_stat | is_ien | is_idis | is_imask;
  wire [1:0]   cfg_idx   = paddr[3:2];
  wire         tx_wr     = wr_fire & is_tx;
  wire [31:0]  bus_cfg;
  wire [31:0]  bank_cfg;

  // Select wanted by the pending character, or the fixed one
  wire [3:0]   want_pcs  = var_sel ? hold_pcs : fixed_pcs;
  wire [1:0]   want_cs   = pcs_index(want_pcs);

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  // mask view read
  wire [31:0]  rd_mux =
      is_cfg   ? bus_cfg :
      is_ctrl  ? {31'h0, enabled} :
      is_mode  ? {12'h0, fixed_pcs, 14'h0, var_sel, 1'b0} :
      is_rx    ? {12'h0, ~(4'h1 << rx_pcs), rx_data} :
      is_stat  ? {15'h0, enabled, 6'h0, status} :
      is_imask ? {22'h0, mask} : 32'h0000_0000;

  spicst_cfg_bank u_bank
  (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (wr_fire & is_cfg),
    .wr_idx    (cfg_idx),
    .wr_data   (pwdata),
    .bus_idx   (cfg_idx),
    .bus_rdata (bus_cfg),
    .eng_idx   (want_cs),
    .eng_rdata (bank_cfg)
  );

  // ------------------------------------------------------------
  // Engine timing terms
  // ------------------------------------------------------------
  wire [7:0]   period    = bit_period(cfg);
  wire [12:0]  half      = {6'h0, period[7:1]};
  wire         phase     = cfg[CF_PHASE];
  wire         pend_ok   = pend & pend_aged & enabled;
  wire         in_shift  = (state == SPICST_SHIFT);
  wire         lead      = ((state == SPICST_SETUP) && (cnt == 13'h1)) || (in_shift && (cnt == 13'h0));
  wire         trail     = in_shift && (cnt == half);
  wire         bit_end   = in_shift && (cnt == {5'h0, period} - 13'h1);
  wire         samp      = phase ? lead : trail;
  wire [4:0]   bits_now  = bits + {4'h0, samp};
  wire [15:0]  rx_next   = samp ? {rx_sh[14:0], miso_s} : rx_sh;
  wire         char_done = bit_end && (bits_now == char_width(cfg));
  // gap of 32 clocks per unit
  wire [12:0]  gap_len   = {5'h0, cfg[CF_GAP_HI:CF_GAP_LO]} << GAP_SHIFT;
  wire         gap_zero  = (cfg[CF_GAP_HI:CF_GAP_LO] == 8'h00);
  wire         gap_done  = (state == SPICST_GAP) && (cnt == 13'h1);
  wire         decide    = (char_done && gap_zero) || gap_done;
  wire         cont      = decide && pend_ok && !cur_last && (want_cs == cur_cs);
  wire         idle_load = (state == SPICST_IDLE) && pend_ok && !(sel_active && (want_cs != cur_cs));
  wire         load      = cont || idle_load;
  // width from the new character's code
  wire [4:0]   new_w     = char_width(bank_cfg);
  wire [15:0]  aligned   = hold_data << (5'h10 - new_w);
  // half period when pre-delay is zero
  wire [7:0]   pre_f     = bank_cfg[CF_PRE_HI:CF_PRE_LO];
  wire [7:0]   new_per   = bit_period(bank_cfg);
  wire [12:0]  pre_len   = (pre_f == 8'h00) ? {6'h0, new_per[7:1]} : {5'h0, pre_f};

  // Events raised by the engine this cycle
  // fixed event bit positions
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_RX_FULL]      = char_done;
  assign ev_set[EV_TX_EMPTY_REG] = load;
  assign ev_set[EV_MODE_FAULT]   = 1'b0;
  assign ev_set[EV_OVERRUN]      = char_done & status[EV_RX_FULL];
  assign ev_set[EV_RX_BUF_END]   = 1'b0;
  assign ev_set[EV_TX_BUF_END]   = 1'b0;
  assign ev_set[EV_RX_BUF_FULL]  = 1'b0;
  assign ev_set[EV_TX_BUF_EMPTY] = 1'b0;
  assign ev_set[EV_SELECT_RISE]  = 1'b0;
  assign ev_set[EV_TX_ALL_EMPTY] = decide & !cont & !pend;

  wire [EV_W-1:0] st_clr = (wr_fire & is_stat) ? pwdata[EV_W-1:0] : {EV_W{1'b0}};

  // ------------------------------------------------------------
  // APB slave handshake
  // ------------------------------------------------------------
  // Two wait cycles so the bank's registered read can settle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready   <= 1'b0;
      ack_wait <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end
    else if (pready)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ack_wait)
    begin
      ack_wait <= 1'b0;
      pready   <= 1'b1;
      prdata   <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr  <= ~mapped;
    end
    else if (psel & penable)
    begin
      ack_wait <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Control, mode and mask registers
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enabled   <= 1'b0;
      var_sel   <= 1'b0;
      fixed_pcs <= PCS_NONE;
      mask      <= {EV_W{1'b0}};
    end
    else
    begin
      if (wr_fire & is_ctrl)
        enabled <= pwdata[CT_ENABLE];
      if (wr_fire & is_mode)
      begin
        var_sel   <= pwdata[MD_VAR_SEL];
        fixed_pcs <= pwdata[PCS_HI:PCS_LO];
      end
      if (wr_fire & is_ien)
        mask <= mask | pwdata[EV_W-1:0];
      else if (wr_fire & is_idis)
        mask <= mask & ~pwdata[EV_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Status flags and interrupt
  // ------------------------------------------------------------
  // A new event beats a write-one clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status <= {EV_W{1'b0}};
      irq    <= 1'b0;
    end
    else
    begin
      status <= (status & ~st_clr) | ev_set;
      irq    <= |(((status & ~st_clr) | ev_set) & mask);
    end
  end

  // ------------------------------------------------------------
  // Transmit holding register
  // ------------------------------------------------------------
  // Overwriting a full holding register replaces the character
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_data <= 16'h0000;
      hold_pcs  <= PCS_NONE;
      hold_last <= 1'b0;
      pend      <= 1'b0;
      pend_aged <= 1'b0;
    end
    else
    begin
      if (tx_wr)
      begin
        hold_data <= pwdata[15:0];
        hold_pcs  <= pwdata[PCS_HI:PCS_LO];
        hold_last <= pwdata[TD_LAST] & var_sel;
      end
      pend      <= tx_wr | (pend & ~load);
      pend_aged <= pend & ~load & ~tx_wr;
    end
  end

  // Data input passes three flops before the engine sees it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      miso_meta <= 2'b00;
      miso_s    <= 1'b0;
    end
    else
    begin
      miso_meta <= {miso_meta[0], miso};
      miso_s    <= miso_meta[1];
    end
  end

  // ------------------------------------------------------------
  // Transfer engine
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state                    <= SPICST_IDLE;
      cfg                      <= CFG_RESET;
      cnt                      <= 13'h0;
      bits                     <= 5'h0;
      tx_sh                    <= 16'h0000;
      rx_sh                    <= 16'h0000;
      rx_data                  <= 16'h0000;
      rx_pcs                   <= 2'd0;
      cur_cs                   <= 2'd0;
      cur_last                 <= 1'b0;
      sel_active               <= 1'b0;
      serial_clock             <= 1'b0;
      mosi                     <= 1'b0;
      peripheral_select_line_n <= 4'hF;
    end
    else
    begin
      // drive on one edge, sample on the other
      if (lead)
        serial_clock <= ~cfg[CF_IDLE_LEVEL];
      if (trail)
        serial_clock <= cfg[CF_IDLE_LEVEL];
      if ((lead && !phase) || (trail && phase))
      begin
        mosi  <= tx_sh[15];
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
      if (samp)
      begin
        rx_sh <= rx_next;
        bits  <= bits_now;
      end
      // keep only the character's own bits
      if (char_done)
      begin
        rx_data <= rx_next & ~(16'hFFFF << char_width(cfg));
        rx_pcs  <= cur_cs;
      end
      if (load)
      begin
        cfg      <= bank_cfg;
        cur_cs   <= want_cs;
        cur_last <= hold_last;
        bits     <= 5'h0;
        rx_sh    <= 16'h0000;
        tx_sh    <= bank_cfg[CF_PHASE] ? {aligned[14:0], 1'b0} : aligned;
        if (bank_cfg[CF_PHASE])
          mosi <= aligned[15];
      end
      case (state)
        SPICST_IDLE:
        begin
          // idle level of the addressed select
          if (!load)
            serial_clock <= bank_cfg[CF_IDLE_LEVEL];
          if (pend_ok && sel_active && (want_cs != cur_cs))
          begin
            // different select releases the held one
            peripheral_select_line_n <= 4'hF;
            sel_active               <= 1'b0;
          end
          else if (idle_load && sel_active)
          begin
            serial_clock <= bank_cfg[CF_IDLE_LEVEL];
            state        <= SPICST_SHIFT;
            cnt          <= 13'h0;
          end
          else if (idle_load)
          begin
            serial_clock             <= bank_cfg[CF_IDLE_LEVEL];
            peripheral_select_line_n <= ~(4'h1 << want_cs);
            sel_active               <= 1'b1;
            state                    <= SPICST_SETUP;
            cnt                      <= (pre_len == 13'h0) ? 13'h1 : pre_len;
          end
        end
        SPICST_SETUP:
        begin
          if (lead)
          begin
            state <= SPICST_SHIFT;
            cnt   <= 13'h1;
          end
          else
            cnt <= cnt - 13'h1;
        end
        SPICST_SHIFT:
        begin
          cnt <= bit_end ? 13'h0 : cnt + 13'h1;
          if (char_done && !gap_zero)
          begin
            state <= SPICST_GAP;
            cnt   <= gap_len;
          end
        end
        SPICST_GAP:
          cnt <= cnt - 13'h1;
        default:
          state <= SPICST_IDLE;
      endcase
      // zero gap continues with no pause
      if (cont)
      begin
        state <= SPICST_SHIFT;
        cnt   <= 13'h0;
      end
      else if (decide)
      begin
        state <= SPICST_IDLE;
        if (!cfg[CF_HOLD] || cur_last)
        begin
          peripheral_select_line_n <= 4'hF;
          sel_active               <= 1'b0;
        end
      end
    end
  end

endmodule

// >>> spicst_monitor.sv
// Port checker for the serial chip-select block
`timescale 1ns/1ps
module spicst_monitor
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        serial_clock,
  input wire logic        mosi,
  input wire logic        miso,
  input wire logic [3:0]  peripheral_select_line_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [3:0] sn = peripheral_select_line_n;  // Active-low selects
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_READY_LAT: assert property (psel && penable && !$past(penable) |-> !pready ##1 !pready ##1 pready)
    else $error("ready latency wrong");
  // Error only for holes in the map
  AST_ERR_MAP: assert property (pready |-> pslverr ==
    (paddr[1:0] != 2'b00 || paddr > 8'h3C || (paddr > 8'h1C && paddr < 8'h30)))
    else $error("error flag disagrees with map");
  AST_WR_ZERO: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("read data on a write");
  AST_ONE_SEL: assert property ($countones(~sn) <= 1)
    else $error("two selects low");
  // A switch passes through all-high first
  AST_SWITCH: assert property (sn != 4'hF && $past(sn) != 4'hF |-> sn == $past(sn))
    else $error("select switched directly");
  cover property (pslverr);
  cover property ($fell(sn[0]));
  cover property ($rose(irq));
endmodule
bind spicst_top spicst_monitor spicst_monitor_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .serial_clock(serial_clock), .mosi(mosi), .miso(miso),
  .peripheral_select_line_n(peripheral_select_line_n));

// >>> spicst_slave_model.sv
// Serial slave on select line 0: captures bits, returns a reply
`timescale 1ns/1ps
module spicst_slave_model
(
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic [3:0]  sel_n,
  input  wire logic        idle_lvl,
  input  wire logic        cap_lead,
  input  wire logic [15:0] reply,
  output logic             miso,
  output logic      [15:0] got
);
  logic [15:0] tsr;  // Reply shifter, left-justified
  initial miso = 1'b0;
  initial got = 16'h0000;
  always @(negedge sel_n[0])
  begin
    tsr = reply;
    miso = reply[15];
    got = 16'h0000;
  end
  // Released line must not keep its last value
  always @(posedge sel_n[0]) miso = ~miso;
  always @(sclk)
    if (!sel_n[0])
    begin
      if ((sclk != idle_lvl) == cap_lead)
        got = {got[14:0], mosi};
      else if (sclk != idle_lvl)
      begin
        miso = tsr[15];
        tsr = tsr << 1;
      end
      else
      begin
        tsr = tsr << 1;
        miso = tsr[15];
      end
    end
endmodule

// >>> tb_spicst_top.sv
// Self-checking bench for the serial chip-select block
`timescale 1ns/1ps
module tb_spicst_top;
  import spicst_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, sclk, mosi, miso, err, idle_lvl = 1'b0, cap_lead = 1'b0;
  logic [3:0]  sel_n;
  logic [15:0] reply = 16'h0000, got;
  int          err_total = 0, comparisons = 0, pre, n, span, tail, tail0;
  always #25 clk = ~clk;
  spicst_top spicst_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .serial_clock(sclk), .mosi(mosi), .miso(miso), .peripheral_select_line_n(sel_n));
  spicst_slave_model spicst_slave_model_i (.sclk(sclk), .mosi(mosi), .sel_n(sel_n), .idle_lvl(idle_lvl),
    .cap_lead(cap_lead), .reply(reply), .miso(miso), .got(got));
  task finish_test;
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // APB cycle; an idle edge follows so back-to-back calls never collide
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    if (i == 50)
    begin
      err_total++;
      finish_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // One or two characters on select 0 (d2 zero: none); times the frame in clock cycles
  task xfer(input logic [31:0] cfg, input logic [31:0] d, input logic [31:0] d2);
    int t0, first, last, i;
    logic prev;
    apb(1'b1, OFF_CFG0, cfg);
    apb(1'b1, OFF_TXDATA, d);
    if (d2 != 32'h0)
      apb(1'b1, OFF_TXDATA, d2);
    t0 = -1;
    first = -1;
    last = 0;
    n = 0;
    tail = -1;
    prev = sclk;
    for (i = 0; i < 3000 && tail < 0; i++)
    begin
      @(posedge clk);
      if (t0 < 0 && !sel_n[0])
        t0 = i;
      if (t0 >= 0 && sclk !== prev)
      begin
        if (first < 0)
          first = i;
        last = i;
        n++;
      end
      prev = sclk;
      if (t0 >= 0 && sel_n[0])
        tail = i - last;
    end
    pre = first - t0;
    span = last - first;
    if (tail < 0)
    begin
      err_total++;
      finish_test;
    end
  endtask
  task t_regs;
    for (int k = 0; k < 4; k++) rchk(OFF_CFG0 + 8'(k * 4), CFG_RESET);
    rchk(OFF_IMASK, 32'h0);
    for (int k = 0; k < 4; k++) apb(1'b1, OFF_CFG0 + 8'(k * 4), 32'h1111_1111 * (k + 1));
    for (int k = 0; k < 4; k++) rchk(OFF_CFG0 + 8'(k * 4), 32'h1111_1111 * (k + 1));
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    check(err, 1'b1);
    rchk(8'h40, 32'h0);
    apb(1'b1, OFF_IMASK, 32'hFFFF_FFFF);
    rchk(OFF_IMASK, 32'h0);
  endtask
  task t_frame_a;
    reply = 16'h3C00;
    xfer({8'h00, 8'h05, 8'h08, 8'h00}, 32'h0000_00A5, 32'h0);
    tail0 = tail;
    check(32'(pre), 32'd5);
    check(32'(n), 32'd16);
    check(32'(span), 32'd60);
    check(got[7:0], 8'hA5);
    check(sclk, 1'b0);
    rchk(OFF_RXDATA, 32'h000E_003C);
  endtask
  task t_frame_b;
    idle_lvl = 1'b1;
    cap_lead = 1'b1;
    reply = 16'h5AF0;
    xfer({8'h01, 8'h00, 8'h08, 8'h83}, 32'h0000_C3A5, 32'h0);
    check(32'(pre), 32'd4);
    check(32'(n), 32'd32);
    check(32'(span), 32'd124);
    check(32'(tail), 32'(tail0 + 32));
    check(got, 16'hC3A5);
    check(sclk, 1'b1);
    rchk(OFF_RXDATA, 32'h000E_5AF0);
  endtask
  task t_irq;
    rchk(OFF_STATUS, 32'h0001_020B);
    check(irq, 1'b0);
    apb(1'b1, OFF_IEN, 32'h3FF);
    rchk(OFF_IMASK, 32'h3FF);
    check(irq, 1'b1);
    apb(1'b1, OFF_IDIS, 32'h155);
    rchk(OFF_IMASK, 32'h2AA);
    apb(1'b1, OFF_STATUS, 32'h20A);
    rchk(OFF_STATUS, 32'h0001_0001);
    check(irq, 1'b0);
    apb(1'b1, OFF_IDIS, 32'h3FF);
    rchk(OFF_IMASK, 32'h0);
  endtask
  // Variable select, hold set, two characters with no gap, the second flagged last
  task t_hold;
    reply = 16'h5AF0;
    apb(1'b1, OFF_MODE, 32'h2);
    xfer({8'h00, 8'h20, 8'h08, 8'h0B}, 32'h0000_00A5, 32'h0100_003C);
    check(32'(n), 32'd32);
    check(32'(span), 32'd124);
    check(32'(tail), 32'(tail0));
    check(got, 16'hA53C);
    rchk(OFF_RXDATA, 32'h000E_00F0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_MODE, 32'h0);
    t_frame_a;
    t_frame_b;
    t_irq;
    t_hold;
    finish_test;
  end
endmodule
